/* verilog/mission_setup_scratchpad_cmds.sv */
`timescale 1ns/1ns
`default_nettype none
module mission_setup_scratchpad_cmds
    import mission_cmd_pkg::*;
#(
    parameter int RST_MIN_CYC_P = RST_MIN_CYC,
    parameter int PD_LOW_CYC_P  = PD_LOW_CYC,
    parameter int CLEAR_CYC_P   = CLEAR_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        dq_in,
    output logic             dq_out,
    output logic             dq_oe,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        tx_taken,
    output logic [7:0]       tx_data,
    input  wire logic        mission_start,
    output logic [55:0]      rtc_value,
    output logic [7:0]       control_byte,
    output logic             mission_active,
    output logic             memory_cleared,
    output logic             log_clear_busy
);
    localparam int CCW = $clog2(CLEAR_CYC_P + 1);

    if (CLEAR_CYC_P < 1 || CLEAR_CYC_P > CLEAR_CYC) begin : g_bad_par
        $error("clear time must be 1 to CLEAR_CYC cycles");
    end

    // Reflected CRC-16, one byte LSB first
    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ CRC_POLY_R;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction : crc16_byte

    cmd_state_t     state_r;
    logic [7:0]     ta1_r;
    logic [7:0]     ta2_r;
    logic [4:0]     end_off_r;
    logic           aa_r;
    logic [7:0]     scratch_r [32];
    logic [4:0]     wptr_r;
    logic [5:0]     sidx_r;
    logic [15:0]    crc_r;
    logic [7:0]     tx_data_r;
    logic [1:0]     auth_cnt_r;
    logic           auth_ok_r;
    logic [4:0]     cidx_r;
    logic [7:0]     rtc_r [7];
    logic [7:0]     ctl_r;
    logic           mip_r;
    logic           memory_cleared_flag_r;
    logic [CCW-1:0] clr_cnt_r;
    logic           clr_busy_r;
    logic           bus_reset;
    logic [15:0]    crc_rx;
    logic [15:0]    crc_tx;
    logic [7:0]     es_byte;
    logic [4:0]     rd_pos;
    logic           rd_last;
    logic [5:0]     sidx_inc;
    logic [7:0]     rd_nxt;
    logic [7:0]     auth_exp;
    logic           copy_wr;
    logic [15:0]    copy_addr;
    logic [7:0]     copy_data;
    logic           rtc_hit;
    logic           clr_go;
    logic           clr_done;

    presence_gen #(
        .RST_MIN_CYC_P (RST_MIN_CYC_P),
        .PD_LOW_CYC_P  (PD_LOW_CYC_P)
    ) u_presence (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .dq_in     (dq_in),
        .dq_out    (dq_out),
        .dq_oe     (dq_oe),
        .bus_reset (bus_reset)
    );

    // Byte-path helpers shared by the sequencer and the checks
    assign crc_rx   = crc16_byte(crc_r, rx_data);
    assign crc_tx   = crc16_byte(crc_r, tx_data_r);
    assign es_byte  = {aa_r, 2'b00, end_off_r};
    assign rd_pos   = ta1_r[4:0] + sidx_r[4:0] - 5'd3;
    assign rd_last  = (sidx_r >= 6'd3) && (rd_pos == SP_LAST);
    assign sidx_inc = sidx_r + 6'd1;

    // Next byte of the read-back: header first, then data from start offset
    always_comb begin
        unique case (sidx_inc)
            6'd1:    rd_nxt = ta2_r;
            6'd2:    rd_nxt = es_byte;
            default: rd_nxt = scratch_r[ta1_r[4:0] + sidx_inc[4:0] - 5'd3];
        endcase
    end

    // Authorization bytes expected in arrival order
    always_comb begin
        unique case (auth_cnt_r)
            2'd0:    auth_exp = ta1_r;
            2'd1:    auth_exp = ta2_r;
            default: auth_exp = es_byte;
        endcase
    end

    // Command sequencer; a bus reset always restarts at the ROM byte
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r    <= ST_IDLE;
            ta1_r      <= 8'h00;
            ta2_r      <= 8'h00;
            end_off_r  <= 5'h00;
            aa_r       <= 1'b0;
            wptr_r     <= 5'h00;
            sidx_r     <= 6'h00;
            crc_r      <= CRC_INIT;
            tx_data_r  <= LOOP_FAIL;
            auth_cnt_r <= 2'h0;
            auth_ok_r  <= 1'b0;
            cidx_r     <= 5'h00;
        end else if (bus_reset) begin
            state_r   <= ST_ROM;
            crc_r     <= CRC_INIT;
            tx_data_r <= LOOP_FAIL;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                end
                ST_ROM: if (rx_valid) begin
                    state_r <= (rx_data == ROM_SKIP) ? ST_FUNC : ST_IDLE;
                end
                ST_FUNC: if (rx_valid) begin
                    crc_r <= crc_rx;
                    unique case (rx_data)
                        FN_WRITE_SP: begin
                            state_r <= ST_TA1;
                            aa_r    <= 1'b0;
                        end
                        FN_READ_SP: begin
                            state_r   <= ST_RSEND;
                            sidx_r    <= 6'h00;
                            tx_data_r <= ta1_r;
                        end
                        FN_COPY_SP: begin
                            state_r    <= ST_CAUTH;
                            auth_cnt_r <= 2'h0;
                            auth_ok_r  <= 1'b1;
                        end
                        default: state_r <= ST_IDLE;
                    endcase
                end
                ST_TA1: if (rx_valid) begin
                    ta1_r   <= rx_data;
                    crc_r   <= crc_rx;
                    state_r <= ST_TA2;
                end
                ST_TA2: if (rx_valid) begin
                    ta2_r     <= rx_data;
                    crc_r     <= crc_rx;
                    wptr_r    <= ta1_r[4:0];
                    end_off_r <= ta1_r[4:0];
                    state_r   <= ST_WDATA;
                end
                ST_WDATA: if (rx_valid) begin
                    crc_r     <= crc_rx;
                    end_off_r <= wptr_r;
                    wptr_r    <= wptr_r + 5'd1;
                    if (wptr_r == SP_LAST) begin
                        state_r   <= ST_TXCRC;
                        sidx_r    <= 6'h00;
                        tx_data_r <= ~crc_rx[7:0];
                    end
                end
                ST_RSEND: if (tx_taken) begin
                    crc_r  <= crc_tx;
                    sidx_r <= sidx_inc;
                    if (rd_last) begin
                        state_r   <= ST_TXCRC;
                        sidx_r    <= 6'h00;
                        tx_data_r <= ~crc_tx[7:0];
                    end else begin
                        tx_data_r <= rd_nxt;
                    end
                end
                ST_TXCRC: if (tx_taken) begin
                    if (sidx_r == 6'h00) begin
                        sidx_r    <= 6'h01;
                        tx_data_r <= ~crc_r[15:8];
                    end else begin
                        state_r   <= ST_LOOP;
                        tx_data_r <= LOOP_FAIL;
                    end
                end
                ST_CAUTH: if (rx_valid) begin
                    auth_cnt_r <= auth_cnt_r + 2'd1;
                    auth_ok_r  <= auth_ok_r && (rx_data == auth_exp);
                    cidx_r     <= ta1_r[4:0];
                    if (auth_cnt_r == 2'd2) begin
                        if (auth_ok_r && (rx_data == auth_exp)) begin
                            state_r <= ST_COPY;
                        end else begin
                            state_r   <= ST_LOOP;
                            tx_data_r <= LOOP_FAIL;
                        end
                    end
                end
                ST_COPY: begin
                    cidx_r <= cidx_r + 5'd1;
                    if (cidx_r == end_off_r) begin
                        aa_r      <= 1'b1;
                        state_r   <= ST_LOOP;
                        tx_data_r <= LOOP_OK;
                    end
                end
                ST_LOOP: begin
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Scratchpad storage; only the write phase touches it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                scratch_r[i] <= 8'h00;
            end
        end else if (state_r == ST_WDATA && rx_valid) begin
            scratch_r[wptr_r] <= rx_data;
        end
    end

    // Copy walks one byte per cycle from start to ending offset
    assign copy_wr   = (state_r == ST_COPY);
    assign copy_addr = {ta2_r, ta1_r[7:5], cidx_r};
    assign copy_data = scratch_r[cidx_r];
    assign rtc_hit   = (copy_addr >= RTC_BASE) && (copy_addr <= RTC_LAST);

    // Clock and control registers; addresses outside the map are ignored
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < 7; i++) begin
                rtc_r[i] <= RTC_RESET;
            end
            ctl_r <= CTL_RESET;
        end else begin
            if (copy_wr && rtc_hit) begin
                rtc_r[copy_addr[2:0]] <= copy_data;
            end
            // One clear per enable, so a stray command cannot wipe a new log
            if (clr_done) begin
                ctl_r[CTL_CLR_EN_BIT] <= 1'b0;
            end
            // Copied value comes last, so a fresh enable wins over the self-clear
            if (copy_wr && copy_addr == CTL_ADDR) begin
                ctl_r <= copy_data;
            end
        end
    end

    // Mission flag: start sets it, a copied zero clears it; set wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mip_r <= 1'b0;
        end else if (mission_start) begin
            mip_r <= 1'b1;
        end else if (copy_wr && copy_addr == STAT_ADDR && !copy_data[STAT_MIP_BIT]) begin
            mip_r <= 1'b0;
        end
    end

    // Cleared flag: clear completion sets it, a new mission drops it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            memory_cleared_flag_r <= 1'b0;
        end else if (clr_done) begin
            memory_cleared_flag_r <= 1'b1;
        end else if (mission_start) begin
            memory_cleared_flag_r <= 1'b0;
        end
    end

    // Clear needs the enable, a running oscillator and no mission
    assign clr_go = (state_r == ST_FUNC) && rx_valid && (rx_data == FN_CLEAR) &&
                    ctl_r[CTL_CLR_EN_BIT] && !ctl_r[CTL_OSC_OFF_BIT] && !mip_r;
    assign clr_done = clr_busy_r && (clr_cnt_r == '0);

    // Clear timer; busy never outlasts the settling wait
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            clr_busy_r <= 1'b0;
            clr_cnt_r  <= '0;
        end else if (clr_go && !clr_busy_r) begin
            clr_busy_r <= 1'b1;
            clr_cnt_r  <= CCW'(CLEAR_CYC_P - 1);
        end else if (clr_done) begin
            clr_busy_r <= 1'b0;
        end else if (clr_busy_r) begin
            clr_cnt_r <= clr_cnt_r - 1'b1;
        end
    end

    assign tx_data        = tx_data_r;
    assign rtc_value      = {rtc_r[6], rtc_r[5], rtc_r[4], rtc_r[3],
                             rtc_r[2], rtc_r[1], rtc_r[0]};
    assign control_byte   = ctl_r;
    assign mission_active = mip_r;
    assign memory_cleared = memory_cleared_flag_r;
    assign log_clear_busy = clr_busy_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset || bus_reset);

    sequence s_hdr_ta1;
        state_r == ST_RSEND && sidx_r == 6'h00 && tx_taken;
    endsequence
    sequence s_hdr_ta2;
        state_r == ST_RSEND && sidx_r == 6'h01 && tx_taken;
    endsequence

    mip_stop_a: assert property (copy_wr && copy_addr == STAT_ADDR &&
        !copy_data[STAT_MIP_BIT] && !mission_start |=> !mission_active)
        else $error("mission not stopped by copied zero");
    rtc_load_a: assert property (copy_wr && copy_addr == RTC_BASE
        |=> rtc_value[7:0] == $past(copy_data))
        else $error("clock byte not loaded");
    skip_accept_a: assert property (state_r == ST_ROM && rx_valid && rx_data == ROM_SKIP
        |=> state_r == ST_FUNC)
        else $error("skip byte not accepted");
    write_store_a: assert property (state_r == ST_WDATA && rx_valid
        |=> scratch_r[$past(wptr_r)] == $past(rx_data) && wptr_r == $past(wptr_r) + 5'd1)
        else $error("scratchpad byte not stored");
    ta_low_a: assert property (state_r == ST_TA2 && rx_valid
        |=> wptr_r == ta1_r[4:0] && ta2_r == $past(rx_data))
        else $error("start offset not taken from low address");
    read_order_a: assert property (s_hdr_ta1 |=> tx_data_r == ta2_r)
        else $error("read header order wrong");
    read_es_a: assert property (s_hdr_ta2 |=> tx_data_r == es_byte)
        else $error("status byte not third");
    es_report_a: assert property (state_r == ST_WDATA && rx_valid
        |=> es_byte[4:0] == $past(wptr_r) && es_byte[6:5] == 2'b00)
        else $error("ending offset wrong");
    crc_end_a: assert property (state_r == ST_WDATA && rx_valid && wptr_r == SP_LAST
        |=> state_r == ST_TXCRC && tx_data_r == ~$past(crc_rx[7:0]))
        else $error("check code missing at end offset");
    no_crc_a: assert property (state_r == ST_WDATA && rx_valid && wptr_r != SP_LAST
        |=> state_r == ST_WDATA)
        else $error("check code sent early");
    copy_ok_a: assert property (copy_wr && cidx_r == end_off_r
        |=> state_r == ST_LOOP && tx_data_r == LOOP_OK && aa_r)
        else $error("copy success answer wrong");
    copy_bad_a: assert property (state_r == ST_CAUTH && rx_valid && auth_cnt_r == 2'd2 &&
        !(auth_ok_r && rx_data == auth_exp) |=> tx_data_r == LOOP_FAIL && !copy_wr [*3])
        else $error("failed copy not refused");
    clear_refuse_a: assert property (state_r == ST_FUNC && rx_valid && rx_data == FN_CLEAR &&
        !ctl_r[CTL_CLR_EN_BIT] && !clr_busy_r |=> !log_clear_busy)
        else $error("clear accepted without enable");
    clear_bound_a: assert property (clr_busy_r |-> clr_cnt_r < CCW'(CLEAR_CYC_P))
        else $error("clear outlasts settling time");
    clear_flag_a: assert property (clr_done |=> memory_cleared && !log_clear_busy)
        else $error("cleared flag not set");
endmodule : mission_setup_scratchpad_cmds
`default_nettype wire

/* verilog/mission_cmd_pkg.sv */
`default_nettype none
package mission_cmd_pkg;
    // Clock rate and bus timing
    localparam int CLK_MHZ     = 100;
    localparam int RST_MIN_US  = 480;
    localparam int PD_WAIT_US  = 30;
    localparam int PD_LOW_US   = 120;
    localparam int CLEAR_US    = 500;
    // Least time rounds up, longest time rounds down (whole microseconds here)
    localparam int RST_MIN_CYC = RST_MIN_US * CLK_MHZ;
    localparam int PD_WAIT_CYC = PD_WAIT_US * CLK_MHZ;
    localparam int PD_LOW_CYC  = PD_LOW_US * CLK_MHZ;
    localparam int CLEAR_CYC   = CLEAR_US * CLK_MHZ;

    // Command bytes and loop answers
    localparam logic [7:0] ROM_SKIP    = 8'hCC;
    localparam logic [7:0] FN_WRITE_SP = 8'h0F;
    localparam logic [7:0] FN_READ_SP  = 8'hAA;
    localparam logic [7:0] FN_COPY_SP  = 8'h55;
    localparam logic [7:0] FN_CLEAR    = 8'h3C;
    localparam logic [7:0] LOOP_OK     = 8'hAA;
    localparam logic [7:0] LOOP_FAIL   = 8'hFF;

    // Register addresses, field positions, reset values
    localparam logic [15:0] RTC_BASE   = 16'h0200;
    localparam logic [15:0] RTC_LAST   = 16'h0206;
    localparam logic [15:0] CTL_ADDR   = 16'h020E;
    localparam logic [15:0] STAT_ADDR  = 16'h0214;
    localparam int          CTL_OSC_OFF_BIT = 7;
    localparam int          CTL_CLR_EN_BIT  = 6;
    localparam int          STAT_MIP_BIT    = 5;
    localparam int          STAT_MEMORY_CLEARED_FLAG_BIT = 3;
    localparam logic [7:0]  CTL_RESET  = 8'h00;
    localparam logic [7:0]  RTC_RESET  = 8'h00;
    localparam logic [4:0]  SP_LAST    = 5'h1F;
    localparam logic [15:0] CRC_INIT   = 16'h0000;
    localparam logic [15:0] CRC_POLY_R = 16'hA001;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_ROM   = 4'h1,
        ST_FUNC  = 4'h3,
        ST_TA1   = 4'h2,
        ST_TA2   = 4'h6,
        ST_WDATA = 4'h7,
        ST_TXCRC = 4'h5,
        ST_RSEND = 4'h4,
        ST_CAUTH = 4'hC,
        ST_COPY  = 4'hD,
        ST_LOOP  = 4'hF
    } cmd_state_t;
endpackage : mission_cmd_pkg
`default_nettype wire

/* verilog/presence_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module presence_gen
    import mission_cmd_pkg::*;
#(
    parameter int RST_MIN_CYC_P = RST_MIN_CYC,
    parameter int PD_LOW_CYC_P  = PD_LOW_CYC
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic dq_in,
    output logic      dq_out,
    output logic      dq_oe,
    output logic      bus_reset
);
    localparam int CW = $clog2(RST_MIN_CYC_P + PD_LOW_CYC_P + PD_WAIT_CYC + 1);

    if (RST_MIN_CYC_P < 2 || PD_LOW_CYC_P < 1) begin : g_bad_par
        $error("presence_gen: timing parameters too small");
    end

    logic [2:0]    sync_r;
    logic          lvl_r;
    logic          lvl_d_r;
    logic [CW-1:0] low_cnt_r;
    logic [CW-1:0] pd_cnt_r;
    logic          pd_wait_r;
    logic          dq_oe_r;
    logic          bus_reset_r;

    // Three stages; a level counts once the last two agree
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync_r  <= 3'h7;
            lvl_r   <= 1'b1;
            lvl_d_r <= 1'b1;
        end else begin
            sync_r  <= {sync_r[1:0], dq_in};
            lvl_d_r <= lvl_r;
            if (sync_r[1] == sync_r[2]) begin
                lvl_r <= sync_r[2];
            end
        end
    end

    // Measure master low time; long enough and released means bus reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            low_cnt_r   <= '0;
            bus_reset_r <= 1'b0;
        end else begin
            bus_reset_r <= lvl_r && !lvl_d_r && (low_cnt_r >= CW'(RST_MIN_CYC_P));
            if (lvl_r || dq_oe_r) begin
                low_cnt_r <= '0;
            end else if (low_cnt_r != CW'(RST_MIN_CYC_P)) begin
                low_cnt_r <= low_cnt_r + 1'b1;
            end
        end
    end

    // Presence answer: wait, then pull the line low for a fixed time
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pd_cnt_r  <= '0;
            pd_wait_r <= 1'b0;
            dq_oe_r   <= 1'b0;
        end else if (bus_reset_r) begin
            pd_cnt_r  <= CW'(PD_WAIT_CYC - 1);
            pd_wait_r <= 1'b1;
            dq_oe_r   <= 1'b0;
        end else if (pd_cnt_r != '0) begin
            pd_cnt_r <= pd_cnt_r - 1'b1;
        end else if (pd_wait_r) begin
            pd_wait_r <= 1'b0;
            dq_oe_r   <= 1'b1;
            pd_cnt_r  <= CW'(PD_LOW_CYC_P - 1);
        end else begin
            dq_oe_r <= 1'b0;
        end
    end

    assign dq_out    = 1'b0;
    assign dq_oe     = dq_oe_r;
    assign bus_reset = bus_reset_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    presence_delay_a: assert property (bus_reset_r |=> !dq_oe_r [*8])
        else $error("presence driven too soon after bus reset");
endmodule : presence_gen
`default_nettype wire

/* tb/master_model.sv */
`timescale 1ns/1ns
`default_nettype none
module master_model (
    input  wire logic       clk_sys,
    input  wire logic       dq_oe,
    input  wire logic [7:0] tx_data,
    output logic            dq_in,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            tx_taken
);
    logic pull_low;
    // Pulled-up line: low while either party pulls it
    assign dq_in = ~(pull_low | dq_oe);
    initial begin
        pull_low = 1'b0;
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_taken = 1'b0;
    end
    // Long low, then wait for presence; bounded by the fixed presence delay
    task automatic bus_reset(output logic ok);
        int n;
        ok = 1'b0;
        @(posedge clk_sys);
        #1 pull_low = 1'b1;
        repeat (60) @(posedge clk_sys);
        #1 pull_low = 1'b0;
        for (n = 0; n < 3300 && !ok; n++) begin
            @(posedge clk_sys);
            #1 ok = (dq_oe === 1'b1);
        end
        repeat (30) @(posedge clk_sys);
    endtask : bus_reset
    // Released data shows the inverse so stale bytes never pass
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys);
        #1 rx_valid = 1'b1;
        rx_data = b;
        @(posedge clk_sys);
        #1 rx_valid = 1'b0;
        rx_data = ~b;
    endtask : send
    task automatic recv(output logic [7:0] b);
        @(posedge clk_sys);
        #1 b = tx_data;
        tx_taken = 1'b1;
        @(posedge clk_sys);
        #1 tx_taken = 1'b0;
    endtask : recv
endmodule : master_model
`default_nettype wire

/* tb/test_mission_setup_scratchpad_cmds.sv */
`timescale 1ns/1ns
`default_nettype none
module test_mission_setup_scratchpad_cmds import mission_cmd_pkg::*;;
    logic        clk_sys, reset, dq_in, dq_out, dq_oe, rx_valid, tx_taken, ok;
    logic [7:0]  rx_data, tx_data, control_byte, got;
    logic [55:0] rtc_value;
    logic [15:0] crc;
    logic        mission_start, mission_active, memory_cleared, log_clear_busy;
    int          mismatches = 0;
    int          n_compared = 0;
    int          i;
    // Offset and value per row; the status row stops the mission
    localparam logic [7:0] ROWS [4][2] = '{'{8'h00, 8'h30}, '{8'h06, 8'h02},
                                           '{8'h14, 8'h00}, '{8'h0E, 8'h40}};
    mission_setup_scratchpad_cmds #(.RST_MIN_CYC_P(40), .PD_LOW_CYC_P(20), .CLEAR_CYC_P(30))
    u_dut (.clk_sys(clk_sys), .reset(reset), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_taken(tx_taken), .tx_data(tx_data),
        .mission_start(mission_start), .rtc_value(rtc_value), .control_byte(control_byte),
        .mission_active(mission_active), .memory_cleared(memory_cleared),
        .log_clear_busy(log_clear_busy));
    master_model u_master (.clk_sys(clk_sys), .dq_oe(dq_oe), .tx_data(tx_data), .dq_in(dq_in),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_taken(tx_taken));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // Reference check code: reflected, LSB first
    function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] d);
        for (int k = 0; k < 8; k++) begin
            c = (c[0] ^ d[k]) ? ((c >> 1) ^ CRC_POLY_R) : (c >> 1);
        end
        return c;
    endfunction : crc_ref
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // About sixteen bus resets of some 3100 cycles each fit well inside this
    initial begin
        repeat (80000) @(posedge clk_sys);
        mismatches++;
        end_sim();
    end
    initial begin
        reset = 1'b1;
        mission_start = 1'b0;
        repeat (20) @(posedge clk_sys);
        #1 reset = 1'b0;
        check("tx_data", tx_data, LOOP_FAIL);
        check("control", control_byte, CTL_RESET);
        check("rtc", rtc_value, 56'h0);
        check("dq_out", dq_out, 1'b0);
        mission_start = 1'b1;
        @(posedge clk_sys);
        #1 mission_start = 1'b0;
        check("mission", mission_active, 1'b1);
        $display("reset test done");
        // Write, read back and verify, then copy, one register per row
        for (i = 0; i < 4; i++) begin
            u_master.bus_reset(ok);
            check("presence", ok, 1'b1);
            u_master.send(ROM_SKIP);
            u_master.send(FN_WRITE_SP);
            u_master.send(ROWS[i][0]);
            u_master.send(8'h02);
            u_master.send(ROWS[i][1]);
            u_master.bus_reset(ok);
            u_master.send(ROM_SKIP);
            u_master.send(FN_READ_SP);
            u_master.recv(got);
            check("ta1", got, ROWS[i][0]);
            u_master.recv(got);
            check("ta2", got, 8'h02);
            u_master.recv(got);
            check("es", got, {3'b000, ROWS[i][0][4:0]});
            u_master.recv(got);
            check("data", got, ROWS[i][1]);
            u_master.bus_reset(ok);
            u_master.send(ROM_SKIP);
            u_master.send(FN_COPY_SP);
            u_master.send(ROWS[i][0]);
            u_master.send(8'h02);
            u_master.send({3'b000, ROWS[i][0][4:0]});
            repeat (3) @(posedge clk_sys);
            #1 check("copy loop", tx_data, LOOP_OK);
            $display("row test done");
        end
        check("rtc", rtc_value, {8'h02, 40'h0, 8'h30});
        check("control", control_byte, 8'h40);
        check("mission", mission_active, 1'b0);
        u_master.bus_reset(ok);
        u_master.send(ROM_SKIP);
        u_master.send(FN_CLEAR);
        @(posedge clk_sys);
        #1 check("busy", log_clear_busy, 1'b1);
        for (i = 0; i < 40 && memory_cleared !== 1'b1; i++)
            @(posedge clk_sys);
        #1 check("cleared", memory_cleared, 1'b1);
        check("clear enable", control_byte[6], 1'b0);
        // Enable has self-cleared, so a second clear must be refused
        u_master.bus_reset(ok);
        u_master.send(ROM_SKIP);
        u_master.send(FN_CLEAR);
        repeat (3) @(posedge clk_sys);
        #1 check("refused", log_clear_busy, 1'b0);
        $display("clear test done");
        u_master.bus_reset(ok);
        u_master.send(ROM_SKIP);
        u_master.send(FN_COPY_SP);
        u_master.send(8'h0E);
        u_master.send(8'h03);
        u_master.send(8'h0E);
        repeat (3) @(posedge clk_sys);
        #1 check("fail loop", tx_data, LOOP_FAIL);
        check("control", control_byte, 8'h00);
        $display("auth test done");
        // Write reaching offset 1Fh must end in the inverted check code
        u_master.bus_reset(ok);
        u_master.send(ROM_SKIP);
        u_master.send(FN_WRITE_SP);
        u_master.send(8'h1F);
        u_master.send(8'h02);
        u_master.send(8'h5A);
        crc = ~crc_ref(crc_ref(crc_ref(crc_ref(CRC_INIT, FN_WRITE_SP), 8'h1F), 8'h02), 8'h5A);
        u_master.recv(got);
        check("crc low", got, crc[7:0]);
        u_master.recv(got);
        check("crc high", got, crc[15:8]);
        u_master.recv(got);
        check("crc loop", got, LOOP_FAIL);
        $display("crc test done");
        // Reset in mid-run returns every register to its idle value
        @(posedge clk_sys);
        #1 reset = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 reset = 1'b0;
        check("tx_data", tx_data, LOOP_FAIL);
        check("rtc", rtc_value, 56'h0);
        check("cleared", memory_cleared, 1'b0);
        check("busy", log_clear_busy, 1'b0);
        $display("second reset test done");
        end_sim();
    end
endmodule : test_mission_setup_scratchpad_cmds
`default_nettype wire
